// file: rtl/pcc_config.v
// register file and control logic for pll ranges, divider sources and control pins
// assumes a byte register port driven on clk_i and asynchronous pin levels
`timescale 1ns/1ps
`include "pcc_defs.vh"
module pcc_config #(
    parameter NUM_DIV = 6                       // post-divider count
) (
    input wire clk_i,                           // device clock
    input wire reset_i,                         // synchronous reset, high
    input wire wr_en_i,                         // register write strobe
    input wire [7:0] addr_i,                    // register offset
    input wire [7:0] wdata_i,                   // write data
    output reg [7:0] rdata_o,                   // read data
    input wire control_pin_a_i,                 // external pin a
    input wire control_pin_b_i,                 // external pin b
    input wire ss_bypass_i,                     // spread bypass chosen
    input wire [1:0] input_source_i,            // input source type field
    input wire [NUM_DIV-1:0] out_invert_i,      // per-output inversion
    input wire bypass_clk_i,                    // input clock level
    input wire pll1_i,                          // pll1 level
    input wire pll2_i,                          // pll2 plain level
    input wire pll2_ss_raw_i,                   // pll2 spread raw level
    input wire pll3_i,                          // pll3 level
    output reg [2:0] vco_range_sel_o,           // vco range per pll
    output reg [3*NUM_DIV-1:0] divider_source_sel_o, // source codes
    output reg pll_pd_o,                        // plls powered down
    output reg input_stage_pd_o,                // input stage powered down
    output reg ss_pd_o,                         // spread circuit powered down
    output reg divider_bypass_o,                // plls and dividers bypassed
    output reg clock_input_one_o,               // input one routed
    output reg [NUM_DIV-1:0] div_src_o,         // per-divider source level
    output reg [NUM_DIV-1:0] out_force_o,       // output forced inactive
    output reg [NUM_DIV-1:0] out_level_o,       // forced output level
    output reg out_oe_n_o                       // output enable, low drives
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    reg [1:0] pin_a_function;                   // pin a function code
    reg [1:0] pin_b_function;                   // pin b function code
    reg input_clock_sel_bit;                    // register clock select
    reg [1:0] pa_sync;                          // pin a synchroniser
    reg [1:0] pb_sync;                          // pin b synchroniser
    reg pll2_ss;                                // gated spread level
    wire pin_a = pa_sync[1];                    // settled pin a
    wire pin_b = pb_sync[1];                    // settled pin b
    wire [NUM_DIV-1:0] mux_out;                 // selector outputs
    reg pa_pd;                                  // pin a power-down active
    reg pb_low;                                 // pin b low-state active
    reg pb_tri;                                 // pin b tri-state active
    reg sel_active;                             // select may apply
    reg next_clk_one;                           // next input one choice
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            pa_sync <= 2'h3;
            pb_sync <= 2'h3;
        end else begin
            pa_sync <= {pa_sync[0], control_pin_a_i};
            pb_sync <= {pb_sync[0], control_pin_b_i};
        end
    end
    // ----------------------------------------
    // register writes
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            vco_range_sel_o <= `PCC_RST_VCO;
            divider_source_sel_o <= {`PCC_RST_SRCX, `PCC_RST_SRCX, `PCC_RST_SRCX,
                                     `PCC_RST_SRCX, `PCC_RST_SRC1, `PCC_RST_SRC0};
            pin_a_function <= `PCC_RST_PIN_FN;
            pin_b_function <= `PCC_RST_PIN_FN;
            input_clock_sel_bit <= `PCC_RST_INSEL;
        end else if (wr_en_i) begin
            case (addr_i)
                `PCC_OFS_VCO_RANGE: begin
                    vco_range_sel_o <= wdata_i[`PCC_VCO_LSB+2:`PCC_VCO_LSB];
                end
                `PCC_OFS_SRC_A: begin
                    divider_source_sel_o[2:0] <= wdata_i[`PCC_SRC_LO_LSB+2:`PCC_SRC_LO_LSB];
                    divider_source_sel_o[5:3] <= wdata_i[`PCC_SRC_HI_LSB+2:`PCC_SRC_HI_LSB];
                end
                `PCC_OFS_CTRL: begin
                    pin_a_function <= wdata_i[`PCC_PIN_A_LSB+1:`PCC_PIN_A_LSB];
                    pin_b_function <= wdata_i[`PCC_PIN_B_LSB+1:`PCC_PIN_B_LSB];
                    input_clock_sel_bit <= wdata_i[`PCC_INSEL_BIT];
                end
                `PCC_OFS_SRC_C: begin
                    divider_source_sel_o[8:6] <= wdata_i[`PCC_SRC_LO_LSB+2:`PCC_SRC_LO_LSB];
                    divider_source_sel_o[11:9] <= wdata_i[`PCC_SRC_HI_LSB+2:`PCC_SRC_HI_LSB];
                end
                `PCC_OFS_SRC_D: begin
                    divider_source_sel_o[14:12] <= wdata_i[`PCC_SRC_LO_LSB+2:`PCC_SRC_LO_LSB];
                    divider_source_sel_o[17:15] <= wdata_i[`PCC_SRC_HI_LSB+2:`PCC_SRC_HI_LSB];
                end
                default: begin
                    // other offsets belong to other blocks
                end
            endcase
        end
    end
    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            rdata_o <= 8'h00;
        end else begin
            case (addr_i)
                `PCC_OFS_VCO_RANGE: rdata_o <= {vco_range_sel_o, 5'h00};
                `PCC_OFS_SRC_A: rdata_o <= {1'b0, divider_source_sel_o[5:3], 1'b0, divider_source_sel_o[2:0]};
                `PCC_OFS_CTRL: rdata_o <= {1'b0, pin_a_function, input_clock_sel_bit, pin_b_function, 2'h0};
                `PCC_OFS_SRC_C: rdata_o <= {1'b0, divider_source_sel_o[11:9], 1'b0, divider_source_sel_o[8:6]};
                `PCC_OFS_SRC_D: rdata_o <= {1'b0, divider_source_sel_o[17:15], 1'b0, divider_source_sel_o[14:12]};
                default: rdata_o <= 8'h00;   // unmapped reads zero
            endcase
        end
    end
    // ----------------------------------------
    // pin function decode
    // ----------------------------------------
    always @* begin
        pa_pd = (pin_a_function == `PCC_PIN_A_PD) && !pin_a;
        pb_low = (pin_b_function == `PCC_PIN_B_LOW) && !pin_b && !pa_pd;
        pb_tri = (pin_b_function == `PCC_PIN_B_TRI) && !pin_b && !pa_pd;
        // only two single-ended inputs allow a choice
        sel_active = (input_source_i == `PCC_IS_LVCMOS);
        if (!sel_active) begin
            next_clk_one = 1'b0;
        end else if (pin_a_function == `PCC_PIN_A_CSEL) begin
            next_clk_one = pin_a;
        end else begin
            next_clk_one = input_clock_sel_bit;
        end
    end
    // ----------------------------------------
    // control outputs
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (reset_i) begin
            pll_pd_o <= 1'b0;
            input_stage_pd_o <= 1'b0;
            ss_pd_o <= 1'b0;
            divider_bypass_o <= 1'b0;
            clock_input_one_o <= 1'b0;
            out_force_o <= {NUM_DIV{1'b0}};
            out_level_o <= {NUM_DIV{1'b0}};
            out_oe_n_o <= 1'b1;
            pll2_ss <= 1'b0;
        end else begin
            divider_bypass_o <= (pin_a_function == `PCC_PIN_A_BYP) && !pin_a;
            pll_pd_o <= pa_pd || ((pin_a_function == `PCC_PIN_A_BYP) && !pin_a);
            input_stage_pd_o <= pa_pd;
            ss_pd_o <= ss_bypass_i;
            pll2_ss <= ss_bypass_i ? 1'b0 : pll2_ss_raw_i;
            clock_input_one_o <= next_clk_one;
            out_force_o <= {NUM_DIV{pb_low}};
            out_level_o <= pb_low ? out_invert_i : {NUM_DIV{1'b0}};
            out_oe_n_o <= pa_pd || pb_tri;
        end
    end
    // ----------------------------------------
    // source selectors and their outputs
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_DIV; g = g + 1) begin : gsel
            pcc_src_sel u_sel (
                .code_i(divider_source_sel_o[3*g+2:3*g]),
                .bypass_i(bypass_clk_i),
                .pll1_i(pll1_i),
                .pll2_i(pll2_i),
                .pll2_ss_i(pll2_ss),
                .pll3_i(pll3_i),
                .out_o(mux_out[g])
            );
        end
    endgenerate
    // register selector outputs
    always @(posedge clk_i) begin
        if (reset_i) begin
            div_src_o <= {NUM_DIV{1'b0}};
        end else begin
            div_src_o <= mux_out;
        end
    end
endmodule

// file: common/pcc_defs.vh
// constants for the pll source and control pin configuration block
// assumes byte-wide registers reached over the documented register port
`ifndef PCC_DEFS_VH
`define PCC_DEFS_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define PCC_OFS_VCO_RANGE 8'h06
`define PCC_OFS_SRC_A 8'h09
`define PCC_OFS_CTRL 8'h0A
`define PCC_OFS_SRC_C 8'h0B
`define PCC_OFS_SRC_D 8'h0C
// ----------------------------------------
// field positions
// ----------------------------------------
`define PCC_VCO_LSB 5
`define PCC_SRC_LO_LSB 0
`define PCC_SRC_HI_LSB 4
`define PCC_PIN_B_LSB 2
`define PCC_INSEL_BIT 4
`define PCC_PIN_A_LSB 5
`define PCC_IS_LSB 6
`define PCC_PD_BIT 7
// ----------------------------------------
// reset values
// ----------------------------------------
`define PCC_RST_VCO 3'h7
`define PCC_RST_SRC0 3'h2
`define PCC_RST_SRC1 3'h4
`define PCC_RST_SRCX 3'h1
`define PCC_RST_PIN_FN 2'h0
`define PCC_RST_INSEL 1'h0
`define PCC_RST_IS 2'h0
// ----------------------------------------
// encodings
// ----------------------------------------
`define PCC_SRC_BYPASS 3'h0
`define PCC_SRC_PLL1 3'h1
`define PCC_SRC_PLL2 3'h2
`define PCC_SRC_PLL2_SS 3'h3
`define PCC_SRC_PLL3 3'h4
`define PCC_PIN_A_PD 2'h0
`define PCC_PIN_A_BYP 2'h1
`define PCC_PIN_A_CSEL 2'h2
`define PCC_PIN_B_LOW 2'h0
`define PCC_PIN_B_TRI 2'h1
`define PCC_IS_LVCMOS 2'h1
`endif

// file: rtl/pcc_src_sel.v
// one post-divider source selector: picks one clock source by code
// assumes source levels arrive already on clk_i
`timescale 1ns/1ps
`include "pcc_defs.vh"
module pcc_src_sel (
    input wire [2:0] code_i,     // selector code
    input wire bypass_i,         // input clock level
    input wire pll1_i,           // pll1 level
    input wire pll2_i,           // pll2 plain level
    input wire pll2_ss_i,        // pll2 spread level
    input wire pll3_i,           // pll3 level
    output reg out_o             // selected level
);
    // ----------------------------------------
    // source multiplexer
    // ----------------------------------------
    always @* begin
        case (code_i)
            `PCC_SRC_BYPASS: out_o = bypass_i;
            `PCC_SRC_PLL1: out_o = pll1_i;
            `PCC_SRC_PLL2: out_o = pll2_i;
            `PCC_SRC_PLL2_SS: out_o = pll2_ss_i;
            `PCC_SRC_PLL3: out_o = pll3_i;
            default: out_o = 1'b0;               // reserved codes give low
        endcase
    end
endmodule

// file: bench/pcc_config_chk.sv
// checker: assertions on the config block ports
// assumes a bind to every pcc_config instance
`timescale 1ns/1ps
`include "pcc_defs.vh"
module pcc_config_chk #(
    parameter NUM_DIV = 6
) (
    input wire clk_i,
    input wire reset_i,
    input wire wr_en_i,
    input wire [7:0] addr_i,
    input wire [7:0] wdata_i,
    input wire control_pin_a_i,
    input wire control_pin_b_i,
    input wire ss_bypass_i,
    input wire [1:0] input_source_i,
    input wire [NUM_DIV-1:0] out_invert_i,
    input wire [2:0] vco_range_sel_o,
    input wire [3*NUM_DIV-1:0] divider_source_sel_o,
    input wire pll_pd_o,
    input wire input_stage_pd_o,
    input wire ss_pd_o,
    input wire divider_bypass_o,
    input wire clock_input_one_o,
    input wire [NUM_DIV-1:0] out_force_o,
    input wire [NUM_DIV-1:0] out_level_o,
    input wire out_oe_n_o
);
// ----
// shadow of the control register fields
// ----
reg [1:0] fa; // pin a function
reg [1:0] fb; // pin b function
reg cs; // select bit
wire [2:0] wd_vco = wdata_i[7:5];
wire [5:0] wd_src = {wdata_i[6:4], wdata_i[2:0]};
// follow host writes to the control register
always @(posedge clk_i) begin
    if (reset_i) begin
        fa <= 2'h0;
        fb <= 2'h0;
        cs <= 1'b0;
    end else if (wr_en_i && addr_i == `PCC_OFS_CTRL) begin
        fa <= wdata_i[6:5];
        fb <= wdata_i[3:2];
        cs <= wdata_i[4];
    end
end
default clocking cb @(posedge clk_i); endclocking
default disable iff (reset_i);
// pin a held low long enough to pass the synchroniser
sequence a_low(logic [1:0] f);
    (fa == f && !control_pin_a_i)[*4];
endsequence
// pin b held low with pin a idle
sequence b_low(logic [1:0] f);
    (control_pin_a_i && fb == f && !control_pin_b_i && $stable(out_invert_i))[*4];
endsequence
vco_reset_a: assert property (disable iff (1'b0) reset_i |=> vco_range_sel_o == `PCC_RST_VCO)
    else $error("vco range not high after reset");
vco_write_a: assert property (wr_en_i && addr_i == `PCC_OFS_VCO_RANGE |=> vco_range_sel_o == $past(wd_vco))
    else $error("vco range write lost");
src_write_a: assert property (wr_en_i && addr_i == `PCC_OFS_SRC_A |=> divider_source_sel_o[5:0] == $past(wd_src))
    else $error("source select write lost");
pin_pd_a: assert property (a_low(2'h0) |-> pll_pd_o && input_stage_pd_o && out_oe_n_o)
    else $error("pin a power down missing");
pd_wins_a: assert property (a_low(2'h0) |-> out_force_o == 0)
    else $error("pin b acts during power down");
pin_byp_a: assert property (a_low(2'h1) |-> divider_bypass_o && pll_pd_o)
    else $error("pin a bypass missing");
pin_csel_a: assert property ((fa == 2'h2 && input_source_i == `PCC_IS_LVCMOS && $stable(control_pin_a_i))[*4]
    |-> clock_input_one_o == control_pin_a_i)
    else $error("pin clock select wrong");
csel_ignored_a: assert property ((input_source_i != `PCC_IS_LVCMOS)[*4] |-> !clock_input_one_o)
    else $error("clock select not ignored");
select_bit_a: assert property ((fa != 2'h2 && input_source_i == `PCC_IS_LVCMOS && $stable(cs))[*4]
    |-> clock_input_one_o == cs)
    else $error("select bit not followed");
pin_low_a: assert property (b_low(2'h0) |-> out_force_o == {NUM_DIV{1'b1}} && out_level_o == out_invert_i
    && !out_oe_n_o)
    else $error("outputs not at inactive level");
pin_tri_a: assert property (b_low(2'h1) |-> out_oe_n_o)
    else $error("outputs not tri-stated");
ss_off_a: assert property (ss_bypass_i[*3] |-> ss_pd_o)
    else $error("spread circuit not powered down");
endmodule
bind pcc_config pcc_config_chk #(.NUM_DIV(NUM_DIV)) pcc_config_chk_inst (
    .clk_i, .reset_i, .wr_en_i, .addr_i, .wdata_i, .control_pin_a_i, .control_pin_b_i, .ss_bypass_i,
    .input_source_i, .out_invert_i, .vco_range_sel_o, .divider_source_sel_o, .pll_pd_o, .input_stage_pd_o,
    .ss_pd_o, .divider_bypass_o, .clock_input_one_o, .out_force_o, .out_level_o, .out_oe_n_o
);

// file: bench/pcc_board_model.sv
// board model: control pins and clock source levels
// assumes requests from the bench on clk_i edges
`timescale 1ns/1ps
module pcc_board_model (
    input wire clk_i,
    input wire pin_a_req_i,
    input wire pin_b_req_i,
    input wire [4:0] lvl_req_i,
    output reg control_pin_a_o = 1'b1,
    output reg control_pin_b_o = 1'b1,
    output reg [4:0] lvl_o = 5'h00
);
// board logic changes its lines just after the clock edge
always @(posedge clk_i) begin
    control_pin_a_o <= pin_a_req_i;
    control_pin_b_o <= pin_b_req_i;
    lvl_o <= lvl_req_i;
end
endmodule

// file: bench/pcc_config_tb.sv
// testbench: registers, source selection and control pins
// assumes the board model stands between bench and pins
`timescale 1ns/1ps
`include "pcc_defs.vh"
module pcc_config_tb;
reg clk_i = 1'b0;
reg reset_i = 1'b1;
reg wr_en_i = 1'b0;
reg [7:0] addr_i = 8'h00;
reg [7:0] wdata_i = 8'h00;
reg pa = 1'b1, pb = 1'b1, ss_bypass_i = 1'b0, chk_vld = 1'b0;
reg [1:0] input_source_i = 2'h1;
reg [5:0] out_invert_i = 6'h00;
reg [4:0] lvl = 5'h00;
reg [31:0] lfsr = 32'hB05F;
reg [7:0] d;
reg [17:0] e; // kind in the top two bits
reg [17:0] q[$]; // expected results, oldest first
reg [7:0] ofs [0:5] = '{8'h06, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h07};
reg [7:0] rst [0:5] = '{8'hE0, 8'h42, 8'h00, 8'h11, 8'h11, 8'h00};
integer bad_count = 0, n_checks = 0, i;
wire pa_w, pb_w, pll_pd_o, input_stage_pd_o, ss_pd_o, divider_bypass_o, clock_input_one_o, out_oe_n_o;
wire [4:0] lvl_w;
wire [7:0] rdata_o;
wire [5:0] div_src_o, out_force_o;
initial forever #20 clk_i = ~clk_i;
pcc_board_model pcc_board_model_inst (.clk_i, .pin_a_req_i(pa), .pin_b_req_i(pb), .lvl_req_i(lvl),
    .control_pin_a_o(pa_w), .control_pin_b_o(pb_w), .lvl_o(lvl_w));
pcc_config pcc_config_inst (.clk_i, .reset_i, .wr_en_i, .addr_i, .wdata_i, .rdata_o, .control_pin_a_i(pa_w),
    .control_pin_b_i(pb_w), .ss_bypass_i, .input_source_i, .out_invert_i, .bypass_clk_i(lvl_w[0]),
    .pll1_i(lvl_w[1]), .pll2_i(lvl_w[2]), .pll2_ss_raw_i(lvl_w[3]), .pll3_i(lvl_w[4]), .vco_range_sel_o(),
    .divider_source_sel_o(), .pll_pd_o, .input_stage_pd_o, .ss_pd_o, .divider_bypass_o, .clock_input_one_o,
    .div_src_o, .out_force_o, .out_level_o(), .out_oe_n_o);
function [31:0] nxt(input [31:0] s);
    nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
endfunction
task conclude;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task cmp(input [15:0] o, input [15:0] x);
    n_checks = n_checks + 1;
    if (o !== x) begin
        bad_count = bad_count + 1;
        $display("wrong value at %0t: got %h expected %h", $time, o, x);
    end
endtask
task cmp_reg(input [15:0] x); cmp({8'h00, rdata_o}, x); endtask
task cmp_ctl(input [15:0] x); cmp({5'h00, pll_pd_o, input_stage_pd_o, divider_bypass_o, clock_input_one_o,
    out_oe_n_o, out_force_o}, x); endtask
task cmp_src(input [15:0] x); cmp({10'h000, div_src_o}, x); endtask
// queue a note, then flag the watcher for one cycle
task note(input [17:0] x);
    q.push_back(x);
    @(posedge clk_i);
    chk_vld <= 1'b1;
    @(posedge clk_i);
    chk_vld <= 1'b0;
endtask
task wr(input [7:0] a, input [7:0] v);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wdata_i <= v;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
endtask
task rd(input [7:0] a, input [7:0] x);
    @(posedge clk_i);
    addr_i <= a;
    note({10'h000, x});
endtask
// program the control register, set pins and source type, expect controls
task pins(input [1:0] fa, input cs, input [1:0] fb, input a, input b, input [1:0] s, input [10:0] x);
    wr(`PCC_OFS_CTRL, {1'b0, fa, cs, fb, 2'h0});
    pa <= a;
    pb <= b;
    input_source_i <= s;
    repeat (6) @(posedge clk_i);
    note({7'h20, x});
endtask
// watcher: compare the oldest note when a result is flagged
always @(posedge clk_i) begin
    if (chk_vld) begin
        e = q.pop_front();
        case (e[17:16])
            2'h0: cmp_reg(e[15:0]);
            2'h1: cmp_ctl(e[15:0]);
            default: cmp_src(e[15:0]);
        endcase
    end
end
initial begin
    repeat (3000) @(posedge clk_i);
    bad_count = bad_count + 1;
    conclude;
end
initial begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    lfsr = nxt(lfsr);
    out_invert_i <= lfsr[13:8];
    for (i = 0; i < 6; i = i + 1) rd(ofs[i], rst[i]);
    for (i = 0; i < 5; i = i + 1) begin
        lfsr = nxt(lfsr);
        d = (i == 0) ? (lfsr[7:0] & 8'hE0) : (i == 2) ? {3'h0, lfsr[4], 1'b0, lfsr[2], 2'h0}
            : {1'b0, lfsr[10:8] % 3'h5, 1'b0, lfsr[2:0] % 3'h5};
        wr(ofs[i], d);
        rd(ofs[i], d);
    end
    $display("register test done");
    for (i = 0; i < 6; i = i + 1) begin
        lfsr = nxt(lfsr);
        lvl <= lfsr[4:0];
        ss_bypass_i <= (i == 5);
        // the same code in every selector, so all six outputs are compared
        d = (i == 5) ? 8'h33 : {1'b0, i[2:0], 1'b0, i[2:0]};
        wr(`PCC_OFS_SRC_A, d);
        wr(`PCC_OFS_SRC_C, d);
        wr(`PCC_OFS_SRC_D, d);
        repeat (5) @(posedge clk_i);
        note({2'h2, 10'h000, {6{(i == 5) ? 1'b0 : lfsr[i]}}});
    end
    $display("source test done");
    pins(2'h0, 1'b0, 2'h0, 1'b0, 1'b1, 2'h1, {5'b11001, 6'h00});
    pins(2'h1, 1'b0, 2'h0, 1'b0, 1'b1, 2'h1, {5'b10100, 6'h00});
    pins(2'h2, 1'b0, 2'h0, 1'b1, 1'b1, 2'h1, {5'b00010, 6'h00});
    pins(2'h2, 1'b1, 2'h0, 1'b0, 1'b1, 2'h1, {5'b00000, 6'h00});
    pins(2'h2, 1'b0, 2'h0, 1'b1, 1'b1, 2'h2, {5'b00000, 6'h00});
    pins(2'h0, 1'b1, 2'h0, 1'b1, 1'b1, 2'h1, {5'b00010, 6'h00});
    pins(2'h0, 1'b1, 2'h0, 1'b1, 1'b1, 2'h0, {5'b00000, 6'h00});
    pins(2'h0, 1'b0, 2'h0, 1'b1, 1'b0, 2'h1, {5'b00000, 6'h3F});
    pins(2'h0, 1'b0, 2'h1, 1'b1, 1'b0, 2'h1, {5'b00001, 6'h00});
    pins(2'h0, 1'b0, 2'h0, 1'b0, 1'b0, 2'h1, {5'b11001, 6'h00});
    $display("pin test done");
    // reset again with the pins idle: range and first source register must read their reset values
    pa <= 1'b1;
    pb <= 1'b1;
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    rd(`PCC_OFS_VCO_RANGE, 8'hE0);
    rd(`PCC_OFS_SRC_A, 8'h42);
    $display("reset test done");
    conclude;
end
endmodule
